// File: design/csf_dev_mep.sv
/*
 * Local down endpoint: builds and parses CSF PDUs, gates transmission on endpoint state,
 * tracks the remote client fault and keeps the CSF statistics.
 * Assumes client_link_up comes from a pin; all other inputs are on core_clk.
 */
// How it works
// - Level field sent and read, three bits
// - Version zero, opcode 52, classify by it
// - Flags 6:4 carry the fault kind
// - Flags 3:1 carry one second or minute
// - Never send zero period; reject on receive
// - TLV offset sent as zero
// - End TLV octet sent as zero
// - Send only while both endpoints are up
// - One client port; reject group member ports
// - Group client down: wait 3.5 intervals first
// - Count frames and clears; clear resets counts
// - Client fault starts periodic sending until up
// - Non-clear PDU raises remote fault
// - Clear PDU or 3.5 periods silence clears fault
// - Sent frames are drop ineligible
`timescale 1ns/100ps
module csf_dev_mep
    import csf_pkg::*;
#(
    parameter logic [39:0] SEC_CYCLES = CSF_SEC_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    csf_link_if.dev link,
    input wire logic client_link_up,
    input wire logic local_mep_up,
    input wire logic remote_mep_up,
    input wire logic tx_enable,
    input wire logic [2:0] mep_level,
    input wire logic [2:0] fault_type,
    input wire logic period_min,
    input wire logic bind_req,
    input wire logic bind_is_group,
    input wire logic bind_port_in_group,
    output logic bound,
    output logic bind_reject,
    output logic remote_fault,
    output logic [2:0] rx_level,
    output logic [2:0] rx_type,
    output logic [15:0] tx_frames,
    output logic [15:0] rx_frames,
    output logic [15:0] tx_clears,
    output logic [15:0] rx_clears,
    input wire logic clear_stats
);
    typedef enum logic [2:0] {
        CSF_ST_IDLE = 3'b001,
        CSF_ST_HOLD = 3'b010,
        CSF_ST_SEND = 3'b100
    } csf_st_t;

    logic link_s1_r, link_s2_r;
    csf_st_t st_r, st_nxt;
    logic [39:0] tx_tmr_r, tx_tmr_nxt;
    logic [39:0] rx_tmr_r, rx_tmr_nxt;
    logic bound_r, bound_nxt, group_r, group_nxt, rej_r, rej_nxt;
    logic out_v_r, out_v_nxt;
    csf_pdu_t out_pdu_r, out_pdu_nxt;
    logic rflt_r, rflt_nxt;
    logic [2:0] rlvl_r, rlvl_nxt, rtyp_r, rtyp_nxt;
    logic [15:0] txf_r, txf_nxt, rxf_r, rxf_nxt, txc_r, txc_nxt, rxc_r, rxc_nxt;
    logic [39:0] iv;
    logic gate, fault, rx_csf, rx_ok;
    logic [2:0] rx_kind;

    // Client link is a pin: two flops before use
    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_s1_r <= 1'b1;
            link_s2_r <= 1'b1;
        end else begin
            link_s1_r <= client_link_up;
            link_s2_r <= link_s1_r;
        end
    end

    assign iv = csf_interval(period_min, SEC_CYCLES);
    assign gate = local_mep_up && remote_mep_up && tx_enable && bound_r;
    assign fault = !link_s2_r;
    assign rx_csf = link.p2d_valid && csf_is_csf(link.p2d_pdu);
    assign rx_ok = rx_csf && csf_per_ok(link.p2d_pdu);
    assign rx_kind = link.p2d_pdu.flags[CSF_TYPE_HI:CSF_TYPE_LO];

    // Binding of the single client port
    always_comb begin
        bound_nxt = bound_r;
        group_nxt = group_r;
        rej_nxt = 1'b0;
        if (bind_req) begin
            if (bound_r || (!bind_is_group && bind_port_in_group)) begin
                rej_nxt = 1'b1;
            end else begin
                bound_nxt = 1'b1;
                group_nxt = bind_is_group;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bound_r <= 1'b0;
            group_r <= 1'b0;
            rej_r <= 1'b0;
        end else begin
            bound_r <= bound_nxt;
            group_r <= group_nxt;
            rej_r <= rej_nxt;
        end
    end

    // Transmit sequencer
    always_comb begin
        st_nxt = st_r;
        tx_tmr_nxt = tx_tmr_r;
        out_v_nxt = 1'b0;
        out_pdu_nxt = out_pdu_r;
        if (!gate) begin
            st_nxt = CSF_ST_IDLE;
            tx_tmr_nxt = CSF_TMR_ZERO;
        end else begin
            unique case (st_r)
                CSF_ST_IDLE: begin
                    if (fault) begin
                        if (group_r) begin
                            st_nxt = CSF_ST_HOLD;
                            tx_tmr_nxt = csf_loss_time(iv);
                        end else begin
                            st_nxt = CSF_ST_SEND;
                            tx_tmr_nxt = CSF_TMR_ZERO;
                        end
                    end
                end
                CSF_ST_HOLD: begin
                    if (!fault) begin
                        st_nxt = CSF_ST_IDLE;
                    end else if (tx_tmr_r <= CSF_TMR_ONE) begin
                        st_nxt = CSF_ST_SEND;
                        tx_tmr_nxt = CSF_TMR_ZERO;
                    end else begin
                        tx_tmr_nxt = tx_tmr_r - CSF_TMR_ONE;
                    end
                end
                CSF_ST_SEND: begin
                    if (!fault) begin
                        // Announce the clear at once instead of leaving the peer to time out
                        st_nxt = CSF_ST_IDLE;
                        out_v_nxt = 1'b1;
                        out_pdu_nxt = csf_build(mep_level, CSF_DCI, period_min);
                    end else if (tx_tmr_r == CSF_TMR_ZERO) begin
                        out_v_nxt = 1'b1;
                        out_pdu_nxt = csf_build(mep_level, fault_type, period_min);
                        tx_tmr_nxt = iv - CSF_TMR_ONE;
                    end else begin
                        tx_tmr_nxt = tx_tmr_r - CSF_TMR_ONE;
                    end
                end
                default: begin
                    st_nxt = CSF_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= CSF_ST_IDLE;
            tx_tmr_r <= CSF_TMR_ZERO;
            out_v_r <= 1'b0;
            out_pdu_r <= CSF_PDU_IDLE;
        end else begin
            st_r <= st_nxt;
            tx_tmr_r <= tx_tmr_nxt;
            out_v_r <= out_v_nxt;
            out_pdu_r <= out_pdu_nxt;
        end
    end

    // Receive side: remote fault with loss timer
    always_comb begin
        rflt_nxt = rflt_r;
        rx_tmr_nxt = rx_tmr_r;
        rlvl_nxt = rlvl_r;
        rtyp_nxt = rtyp_r;
        if (rx_ok) begin
            rlvl_nxt = link.p2d_pdu.level;
            rtyp_nxt = rx_kind;
            if (rx_kind == CSF_DCI) begin
                rflt_nxt = 1'b0;
                rx_tmr_nxt = CSF_TMR_ZERO;
            end else begin
                rflt_nxt = 1'b1;
                rx_tmr_nxt = csf_loss_time(csf_interval(
                    link.p2d_pdu.flags[CSF_PER_HI:CSF_PER_LO] == CSF_PER_1M, SEC_CYCLES));
            end
        end else if (rflt_r) begin
            if (rx_tmr_r <= CSF_TMR_ONE) begin
                rflt_nxt = 1'b0;
                rx_tmr_nxt = CSF_TMR_ZERO;
            end else begin
                rx_tmr_nxt = rx_tmr_r - CSF_TMR_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rflt_r <= 1'b0;
            rx_tmr_r <= CSF_TMR_ZERO;
            rlvl_r <= 3'h0;
            rtyp_r <= 3'h0;
        end else begin
            rflt_r <= rflt_nxt;
            rx_tmr_r <= rx_tmr_nxt;
            rlvl_r <= rlvl_nxt;
            rtyp_r <= rtyp_nxt;
        end
    end

    // Statistics; an event in the clear cycle still counts as one
    always_comb begin
        txf_nxt = clear_stats ? CSF_CNT_ZERO : txf_r;
        rxf_nxt = clear_stats ? CSF_CNT_ZERO : rxf_r;
        txc_nxt = clear_stats ? CSF_CNT_ZERO : txc_r;
        rxc_nxt = clear_stats ? CSF_CNT_ZERO : rxc_r;
        if (out_v_r) begin
            txf_nxt = txf_nxt + CSF_CNT_ONE;
            if (out_pdu_r.flags[CSF_TYPE_HI:CSF_TYPE_LO] == CSF_DCI) begin
                txc_nxt = txc_nxt + CSF_CNT_ONE;
            end
        end
        if (rx_ok) begin
            rxf_nxt = rxf_nxt + CSF_CNT_ONE;
            if (rx_kind == CSF_DCI) begin
                rxc_nxt = rxc_nxt + CSF_CNT_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            txf_r <= CSF_CNT_ZERO;
            rxf_r <= CSF_CNT_ZERO;
            txc_r <= CSF_CNT_ZERO;
            rxc_r <= CSF_CNT_ZERO;
        end else begin
            txf_r <= txf_nxt;
            rxf_r <= rxf_nxt;
            txc_r <= txc_nxt;
            rxc_r <= rxc_nxt;
        end
    end

    assign link.d2p_valid = out_v_r;
    assign link.d2p_pdu = out_pdu_r;
    assign bound = bound_r;
    assign bind_reject = rej_r;
    assign remote_fault = rflt_r;
    assign rx_level = rlvl_r;
    assign rx_type = rtyp_r;
    assign tx_frames = txf_r;
    assign rx_frames = rxf_r;
    assign tx_clears = txc_r;
    assign rx_clears = rxc_r;
endmodule : csf_dev_mep

// File: design/csf_pkg.sv
/*
 * Shared constants, PDU layout and helpers for the client signal fail PDU unit.
 * Assumes a single core clock of 40 MHz and both ends compiled against this package.
 */
package csf_pkg;
    localparam int unsigned CSF_CLK_HZ = 40000000;
    localparam int unsigned CSF_SEC_MS = 1000;
    localparam int unsigned CSF_MIN_S = 60;
    localparam logic [39:0] CSF_SEC_CYC = 40'(longint'(CSF_CLK_HZ) * CSF_SEC_MS / 1000);
    localparam logic [39:0] CSF_MIN_MULT = 40'h00_0000_003C;
    localparam logic [4:0] CSF_VERSION = 5'h00;
    localparam logic [7:0] CSF_OPCODE = 8'h34;
    localparam logic [7:0] CSF_TLV_OFS = 8'h00;
    localparam logic [7:0] CSF_END_TLV = 8'h00;
    localparam int CSF_TYPE_HI = 6;
    localparam int CSF_TYPE_LO = 4;
    localparam int CSF_PER_HI = 3;
    localparam int CSF_PER_LO = 1;
    localparam logic [2:0] CSF_PER_INVALID = 3'h0;
    localparam logic [2:0] CSF_PER_1S = 3'h4;
    localparam logic [2:0] CSF_PER_1M = 3'h6;
    localparam logic [15:0] CSF_CNT_ZERO = 16'h0000;
    localparam logic [15:0] CSF_CNT_ONE = 16'h0001;
    localparam logic [39:0] CSF_TMR_ZERO = 40'h00_0000_0000;
    localparam logic [39:0] CSF_TMR_ONE = 40'h00_0000_0001;

    typedef enum logic [2:0] {
        CSF_LOS = 3'h0,
        CSF_FDI = 3'h1,
        CSF_RDI = 3'h2,
        CSF_DCI = 3'h3
    } csf_type_t;

    typedef struct packed {
        logic [2:0] level;
        logic [4:0] version;
        logic [7:0] opcode;
        logic [7:0] flags;
        logic [7:0] tlv_offset;
        logic [7:0] end_tlv;
        logic drop_elig;
    } csf_pdu_t;

    localparam csf_pdu_t CSF_PDU_IDLE = '0;

    // Bits 7 and 0 of the flags stay zero; the period field is never left at zero
    function automatic csf_pdu_t csf_build(input logic [2:0] level, input logic [2:0] ctype,
                                           input logic per_min);
        csf_pdu_t p;
        p = CSF_PDU_IDLE;
        p.level = level;
        p.version = CSF_VERSION;
        p.opcode = CSF_OPCODE;
        p.flags[CSF_TYPE_HI:CSF_TYPE_LO] = ctype;
        p.flags[CSF_PER_HI:CSF_PER_LO] = per_min ? CSF_PER_1M : CSF_PER_1S;
        p.tlv_offset = CSF_TLV_OFS;
        p.end_tlv = CSF_END_TLV;
        p.drop_elig = 1'b0;
        return p;
    endfunction : csf_build

    function automatic logic csf_is_csf(input csf_pdu_t p);
        return (p.opcode == CSF_OPCODE) && (p.version == CSF_VERSION);
    endfunction : csf_is_csf

    function automatic logic csf_per_ok(input csf_pdu_t p);
        return (p.flags[CSF_PER_HI:CSF_PER_LO] == CSF_PER_1S) || (p.flags[CSF_PER_HI:CSF_PER_LO] == CSF_PER_1M);
    endfunction : csf_per_ok

    function automatic logic [39:0] csf_interval(input logic per_min, input logic [39:0] sec_cyc);
        return per_min ? 40'(sec_cyc * CSF_MIN_MULT) : sec_cyc;
    endfunction : csf_interval

    // Three and a half intervals
    function automatic logic [39:0] csf_loss_time(input logic [39:0] iv);
        return 40'((iv << 1) + iv + (iv >> 1));
    endfunction : csf_loss_time
endpackage : csf_pkg

// File: design/csf_link_if.sv
/*
 * Point-to-point link carrying CSF PDUs between the local endpoint and its peer.
 * Assumes both ends run on core_clk; each PDU is a one-cycle valid pulse, no back-pressure.
 */
`timescale 1ns/100ps
interface csf_link_if
    import csf_pkg::*;
();
    logic d2p_valid;
    csf_pdu_t d2p_pdu;
    logic p2d_valid;
    csf_pdu_t p2d_pdu;

    modport dev (output d2p_valid, output d2p_pdu, input p2d_valid, input p2d_pdu);
    modport peer (input d2p_valid, input d2p_pdu, output p2d_valid, output p2d_pdu);
endinterface : csf_link_if

// File: design/csf_peer_mep.sv
/*
 * Peer endpoint on the remote switch: sends CSF PDUs while its client is down and
 * reports what it receives from the local endpoint.
 * Assumes client_link_up comes from a pin; other inputs are on core_clk.
 */
`timescale 1ns/100ps
module csf_peer_mep
    import csf_pkg::*;
#(
    parameter logic [39:0] SEC_CYCLES = CSF_SEC_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    csf_link_if.peer link,
    input wire logic client_link_up,
    input wire logic [2:0] mep_level,
    input wire logic [2:0] fault_type,
    input wire logic period_min,
    output logic rx_seen,
    output logic rx_valid_pdu,
    output logic [2:0] rx_level,
    output logic [2:0] rx_type
);
    logic link_s1_r, link_s2_r;
    logic [39:0] tmr_r, tmr_nxt;
    logic sending_r, sending_nxt;
    logic out_v_r, out_v_nxt;
    csf_pdu_t out_pdu_r, out_pdu_nxt;
    logic seen_r, seen_nxt, ok_r, ok_nxt;
    logic [2:0] lvl_r, lvl_nxt, typ_r, typ_nxt;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_s1_r <= 1'b1;
            link_s2_r <= 1'b1;
        end else begin
            link_s1_r <= client_link_up;
            link_s2_r <= link_s1_r;
        end
    end

    // Periodic send while the client is down, one clear PDU when it returns
    always_comb begin
        tmr_nxt = tmr_r;
        sending_nxt = sending_r;
        out_v_nxt = 1'b0;
        out_pdu_nxt = out_pdu_r;
        if (!link_s2_r) begin
            sending_nxt = 1'b1;
            if (tmr_r == CSF_TMR_ZERO) begin
                out_v_nxt = 1'b1;
                out_pdu_nxt = csf_build(mep_level, fault_type, period_min);
                tmr_nxt = csf_interval(period_min, SEC_CYCLES) - CSF_TMR_ONE;
            end else begin
                tmr_nxt = tmr_r - CSF_TMR_ONE;
            end
        end else if (sending_r) begin
            sending_nxt = 1'b0;
            tmr_nxt = CSF_TMR_ZERO;
            out_v_nxt = 1'b1;
            out_pdu_nxt = csf_build(mep_level, CSF_DCI, period_min);
        end
    end

    // Parse what the local endpoint sends
    always_comb begin
        seen_nxt = 1'b0;
        ok_nxt = ok_r;
        lvl_nxt = lvl_r;
        typ_nxt = typ_r;
        if (link.d2p_valid && csf_is_csf(link.d2p_pdu)) begin
            seen_nxt = 1'b1;
            ok_nxt = csf_per_ok(link.d2p_pdu);
            lvl_nxt = link.d2p_pdu.level;
            typ_nxt = link.d2p_pdu.flags[CSF_TYPE_HI:CSF_TYPE_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tmr_r <= CSF_TMR_ZERO;
            sending_r <= 1'b0;
            out_v_r <= 1'b0;
            out_pdu_r <= CSF_PDU_IDLE;
            seen_r <= 1'b0;
            ok_r <= 1'b0;
            lvl_r <= 3'h0;
            typ_r <= 3'h0;
        end else begin
            tmr_r <= tmr_nxt;
            sending_r <= sending_nxt;
            out_v_r <= out_v_nxt;
            out_pdu_r <= out_pdu_nxt;
            seen_r <= seen_nxt;
            ok_r <= ok_nxt;
            lvl_r <= lvl_nxt;
            typ_r <= typ_nxt;
        end
    end

    assign link.p2d_valid = out_v_r;
    assign link.p2d_pdu = out_pdu_r;
    assign rx_seen = seen_r;
    assign rx_valid_pdu = ok_r;
    assign rx_level = lvl_r;
    assign rx_type = typ_r;
endmodule : csf_peer_mep

// File: tb/csf_link_assertions.sv
/*
 * Concurrent checks on the link between the two CSF endpoints.
 * Assumes it is instantiated beside the link interface and sees its signals on core_clk.
 */
`timescale 1ns/100ps
module csf_link_assertions
    import csf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic d2p_valid,
    input wire csf_pdu_t d2p_pdu,
    input wire logic p2d_valid,
    input wire csf_pdu_t p2d_pdu
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_dev_header_fixed: assert property (d2p_valid |-> d2p_pdu.version == 5'h00 && d2p_pdu.opcode == 8'h34)
        else $error("device PDU header wrong");
    a_dev_type_legal: assert property (d2p_valid |-> d2p_pdu.flags[6:4] <= 3'h3)
        else $error("device PDU type out of range");
    a_dev_period_legal: assert property (d2p_valid |-> d2p_pdu.flags[3:1] inside {3'h4, 3'h6})
        else $error("device PDU period not legal");
    a_dev_spare_zero: assert property (d2p_valid |-> !d2p_pdu.flags[7] && !d2p_pdu.flags[0])
        else $error("device PDU spare flag set");
    a_dev_offset_zero: assert property (d2p_valid |-> d2p_pdu.tlv_offset == 8'h00)
        else $error("device PDU offset not zero");
    a_dev_end_zero: assert property (d2p_valid |-> d2p_pdu.end_tlv == 8'h00)
        else $error("device PDU end octet not zero");
    a_dev_drop_inelig: assert property (d2p_valid |-> !d2p_pdu.drop_elig)
        else $error("device PDU drop eligible");
    // A clear or a gate drop may follow a fault PDU at once, so only fault PDUs are spaced
    a_dev_frame_spacing: assert property ((d2p_valid && d2p_pdu.flags[6:4] != 3'h3) |=>
        !(d2p_valid && d2p_pdu.flags[6:4] != 3'h3) [*2])
        else $error("device PDUs too close");
    a_peer_header_period: assert property (p2d_valid |-> p2d_pdu.opcode == 8'h34 && p2d_pdu.flags[3:1] != 3'h0)
        else $error("peer PDU header or period wrong");
    a_dev_pdu_hold: assert property (!d2p_valid |-> $stable(d2p_pdu))
        else $error("device PDU changed without strobe");
endmodule : csf_link_assertions

// File: tb/client_signal_fail_pdu_unit_bench.sv
/*
 * Self-checking bench: device and peer endpoints joined by one link, plus a second
 * device whose receive side is fed by the bench. Assumes SEC_CYCLES shortened to 40.
 */
`timescale 1ns/100ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", what, (exp), (got)); end end
module client_signal_fail_pdu_unit_bench;
    import csf_pkg::*;
    localparam logic [39:0] SEC = 40'h00_0000_0028;
    localparam int IV = 40;
    localparam int LOSS = 140;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic dev_up = 1'b1, peer_up = 1'b1, local_up = 1'b1, remote_up = 1'b1, tx_en = 1'b1, per_min = 1'b0;
    logic bind_req = 1'b0, bind_grp = 1'b0, bind_mem = 1'b0, clr = 1'b0;
    logic [2:0] dtype = 3'h0;
    logic bound, bind_reject, remote_fault, p_seen, p_ok, b_fault;
    logic [2:0] rx_level, rx_type, p_level, p_type, b_level;
    logic [15:0] tx_frames, rx_frames, tx_clears, rx_clears, b_rxf, b_rxc;
    int fails = 0, compares = 0, cycles = 0, tx_seen = 0, n, i;
    csf_pdu_t exp;
    logic [7:0] bad_op [3] = '{8'h34, 8'h34, 8'h33};
    logic [7:0] bad_fl [3] = '{8'h00, 8'h0A, 8'h08};

    csf_link_if link();
    csf_link_if link_b();
    csf_dev_mep #(.SEC_CYCLES(SEC)) u_csf_dev_mep (.core_clk(core_clk), .rst(rst), .link(link),
        .client_link_up(dev_up), .local_mep_up(local_up), .remote_mep_up(remote_up), .tx_enable(tx_en),
        .mep_level(3'h5), .fault_type(dtype), .period_min(per_min), .bind_req(bind_req),
        .bind_is_group(bind_grp), .bind_port_in_group(bind_mem), .bound(bound), .bind_reject(bind_reject),
        .remote_fault(remote_fault), .rx_level(rx_level), .rx_type(rx_type), .tx_frames(tx_frames),
        .rx_frames(rx_frames), .tx_clears(tx_clears), .rx_clears(rx_clears), .clear_stats(clr));
    csf_dev_mep #(.SEC_CYCLES(SEC)) u_csf_dev_mep_b (.core_clk(core_clk), .rst(rst), .link(link_b),
        .client_link_up(dev_up), .local_mep_up(local_up), .remote_mep_up(remote_up), .tx_enable(tx_en),
        .mep_level(3'h5), .fault_type(dtype), .period_min(per_min), .bind_req(bind_req),
        .bind_is_group(bind_grp), .bind_port_in_group(bind_mem), .bound(), .bind_reject(),
        .remote_fault(b_fault), .rx_level(b_level), .rx_type(), .tx_frames(), .rx_frames(b_rxf),
        .tx_clears(), .rx_clears(b_rxc), .clear_stats(clr));
    csf_peer_mep #(.SEC_CYCLES(SEC)) u_csf_peer_mep (.core_clk(core_clk), .rst(rst), .link(link),
        .client_link_up(peer_up), .mep_level(3'h2), .fault_type(CSF_RDI), .period_min(1'b0),
        .rx_seen(p_seen), .rx_valid_pdu(p_ok), .rx_level(p_level), .rx_type(p_type));
    csf_link_assertions u_csf_link_assertions (.core_clk(core_clk), .rst(rst), .d2p_valid(link.d2p_valid),
        .d2p_pdu(link.d2p_pdu), .p2d_valid(link.p2d_valid), .p2d_pdu(link.p2d_pdu));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (link.d2p_valid === 1'b1) tx_seen++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask : tick

    // Counts cycles until the device sends, or gives up at lim
    task wait_tx(input int lim, output int k);
        int s;
        s = tx_seen;
        k = 0;
        while (tx_seen == s && k < lim) begin
            tick(1);
            k++;
        end
    endtask : wait_tx

    // After the strobe the bench scrambles the released PDU lines
    task inject(input logic [2:0] lvl, input logic [7:0] fl, input logic [7:0] op);
        link_b.p2d_pdu = '0;
        link_b.p2d_pdu.level = lvl;
        link_b.p2d_pdu.opcode = op;
        link_b.p2d_pdu.flags = fl;
        link_b.p2d_valid = 1'b1;
        tick(1);
        link_b.p2d_valid = 1'b0;
        link_b.p2d_pdu = ~link_b.p2d_pdu;
        tick(1);
    endtask : inject

    // Lets an edge pass first so back-to-back calls never re-raise bind_req in one time step
    task do_bind(input logic grp, input logic mem);
        tick(1);
        bind_grp = grp;
        bind_mem = mem;
        bind_req = 1'b1;
        tick(1);
        bind_req = 1'b0;
    endtask : do_bind

    task end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    initial begin
        link_b.p2d_valid = 1'b0;
        link_b.p2d_pdu = '0;
        tick(16);
        rst = 1'b0;
        tick(2);
        do_bind(1'b0, 1'b1);
        `CHK("member reject", 1'b1, bind_reject);
        `CHK("not bound", 1'b0, bound);
        do_bind(1'b0, 1'b0);
        `CHK("bound", 1'b1, bound);
        do_bind(1'b0, 1'b0);
        `CHK("second bind reject", 1'b1, bind_reject);
        for (i = 0; i < 3; i++) begin
            dtype = 3'(i);
            per_min = (i == 2);
            dev_up = 1'b0;
            wait_tx(20, n);
            `CHK("tx start", 1'b1, n <= 6);
            exp = '0;
            exp.level = 3'h5;
            exp.opcode = 8'h34;
            exp.flags = {1'b0, dtype, per_min ? 3'h6 : 3'h4, 1'b0};
            `CHK("tx pdu", exp, link.d2p_pdu);
            if (i == 0) begin
                wait_tx(60, n);
                `CHK("interval", IV, n);
            end
            `CHK("peer type", dtype, p_type);
            `CHK("peer level", 3'h5, p_level);
            `CHK("peer seen", 1'b1, p_seen);
            `CHK("peer period ok", 1'b1, p_ok);
            dev_up = 1'b1;
            wait_tx(20, n);
            `CHK("clear type", 3'h3, link.d2p_pdu.flags[6:4]);
            tick(2);
        end
        `CHK("tx clears", 16'h0003, tx_clears);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        `CHK("tx frames cleared", 16'h0000, tx_frames);
        `CHK("tx clears cleared", 16'h0000, tx_clears);
        per_min = 1'b0;
        remote_up = 1'b0;
        dev_up = 1'b0;
        wait_tx(100, n);
        `CHK("gated remote", 100, n);
        remote_up = 1'b1;
        wait_tx(20, n);
        `CHK("ungated", 1'b1, n < 20);
        local_up = 1'b0;
        wait_tx(100, n);
        `CHK("gated local", 100, n);
        local_up = 1'b1;
        tx_en = 1'b0;
        wait_tx(100, n);
        `CHK("gated enable", 100, n);
        tx_en = 1'b1;
        dev_up = 1'b1;
        tick(60);
        peer_up = 1'b0;
        n = 0;
        while (remote_fault !== 1'b1 && n < 20) begin tick(1); n++; end
        `CHK("remote fault", 1'b1, remote_fault);
        `CHK("rx type", 3'h2, rx_type);
        `CHK("rx level", 3'h2, rx_level);
        `CHK("rx frames", 16'h0001, rx_frames);
        peer_up = 1'b1;
        n = 0;
        while (remote_fault !== 1'b0 && n < 20) begin tick(1); n++; end
        `CHK("fault cleared", 1'b0, remote_fault);
        `CHK("rx clears", 16'h0001, rx_clears);
        inject(3'h6, 8'h89, 8'h34);
        `CHK("b fault", 1'b1, b_fault);
        `CHK("b level", 3'h6, b_level);
        tick(LOSS - 10);
        `CHK("b fault held", 1'b1, b_fault);
        tick(20);
        `CHK("b fault timeout", 1'b0, b_fault);
        for (i = 0; i < 3; i++) begin
            inject(3'h6, bad_fl[i], bad_op[i]);
            `CHK("b ignored", 1'b0, b_fault);
            `CHK("b rx frames", 16'h0001, b_rxf);
        end
        inject(3'h6, 8'h08, 8'h34);
        inject(3'h6, 8'h38, 8'h34);
        `CHK("b cleared", 1'b0, b_fault);
        `CHK("b rx clears", 16'h0001, b_rxc);
        rst = 1'b1;
        tick(16);
        rst = 1'b0;
        tick(2);
        do_bind(1'b1, 1'b0);
        `CHK("group bound", 1'b1, bound);
        dev_up = 1'b0;
        wait_tx(200, n);
        `CHK("group hold", 1'b1, n >= LOSS && n <= LOSS + 10);
        dev_up = 1'b1;
        tick(20);
        end_of_test();
    end
endmodule : client_signal_fail_pdu_unit_bench
